// File: verilog/clr_rom.sv
/*
 * Clocked, latched 256 x 4 read-only store with enable clear.
 * Assumes host pins are asynchronous and are brought in through clr_sync;
 * the table is given as a parameter at build time.
 */
`timescale 1ns/10ps

`include "clr_regs.svh"

module clr_rom
	import clr_pkg::*;
#(
	parameter clr_table_t ROM_TABLE = '{default: `CLR_WORD_ZERO}
) (
	// clock and reset
	input  wire logic      clk,
	input  wire logic      rst_b,
	// host pins
	input  wire logic      rom_clock,
	input  wire logic      enable,
	input  wire clr_addr_t address,
	// data out
	output clr_word_t      data_out,
	output logic           word_stale
);

	clr_host_t host_pins;
	clr_host_t host;
	clr_state_t state_reg;
	clr_state_t state_next;
	clr_word_t  data_reg;
	clr_word_t  data_next;
	// synced device clock one cycle back; resets low, so a pin idling high
	// gives one false rise after reset, harmless while enable holds the clear
	logic       clock_prev_reg;
	logic       clock_prev_next;
	// saturates at the low-phase limit, 32 bits leave ample headroom
	logic [31:0] low_cnt_reg;
	logic [31:0] low_cnt_next;
	logic       stale_reg;
	logic       stale_next;
	logic       fall;
	logic       rise;
	clr_word_t  table_word;

	// whole bundle in one assignment, so the struct has a single driver
	assign host_pins = '{rom_clock: rom_clock, enable: enable, address: address};

	// every pin takes two flops: two cycles of latency bought against
	// any logic ever seeing a metastable pin
	clr_sync u_sync (
		.clk    (clk),
		.rst_b  (rst_b),
		.pins   (host_pins),
		.synced (host)
	);

	// edges of the synced device clock, at most one of them per cycle
	assign fall = clock_prev_reg & ~host.rom_clock;
	assign rise = ~clock_prev_reg & host.rom_clock;
	// plain binary index, bit 0 of address is the lowest line
	assign table_word = ROM_TABLE[host.address];

	always_comb begin
		state_next      = state_reg;
		data_next       = data_reg;
		clock_prev_next = host.rom_clock;
		low_cnt_next    = low_cnt_reg;
		stale_next      = stale_reg;
		if (!host.enable) begin
			// clear beats any clock activity
			state_next   = CLR_CLEAR;
			data_next    = `CLR_WORD_ZERO;
			low_cnt_next = '0;
			stale_next   = 1'b0;
		end else begin
			case (state_reg)
				CLR_CLEAR: begin
					// enable-driven read: data straight out, no ones pulse
					if (!host.rom_clock) begin
						state_next = CLR_FETCH;
						data_next  = table_word;
					end else begin
						state_next = CLR_HOLD;
						data_next  = table_word;
					end
				end
				CLR_HOLD: begin
					// address moves are ignored, only a clock fall reopens a fetch
					if (fall) begin
						state_next = CLR_PRECHARGE;
						data_next  = `CLR_WORD_ONES;
					end
				end
				CLR_PRECHARGE: begin
					// ones pulse lasts exactly one cycle
					state_next = CLR_FETCH;
					data_next  = table_word;
				end
				CLR_FETCH: begin
					// output follows the address until the clock rises
					if (rise) begin
						state_next = CLR_HOLD;
					end else begin
						data_next = table_word;
					end
				end
				default: begin
					state_next = CLR_CLEAR;
					data_next  = `CLR_WORD_ZERO;
				end
			endcase
			// low phase limit: flag a decayed word so the host refetches
			// advisory only: data_out is not blanked, the host decides
			if (host.rom_clock) begin
				low_cnt_next = '0;
				stale_next   = 1'b0;
			end else if (low_cnt_reg < 32'(`CLR_LOW_MAX_CYC)) begin
				low_cnt_next = low_cnt_reg + 32'h1;
			end else begin
				stale_next = 1'b1;
			end
		end
	end

	// reset values match a store cleared by a low enable
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg      <= CLR_CLEAR;
			data_reg       <= `CLR_WORD_ZERO;
			clock_prev_reg <= 1'b0;
			low_cnt_reg    <= '0;
			stale_reg      <= 1'b0;
		end else begin
			state_reg      <= state_next;
			data_reg       <= data_next;
			clock_prev_reg <= clock_prev_next;
			low_cnt_reg    <= low_cnt_next;
			stale_reg      <= stale_next;
		end
	end

	// outputs straight from flops, no glitch from the table decode
	assign data_out   = data_reg;
	assign word_stale = stale_reg;

	// checks watch the synced pins, so they see what the logic saw

	a_enable_clear: assert property (@(posedge clk) disable iff (!rst_b)
		!host.enable |=> data_out == `CLR_WORD_ZERO)
		else $error("outputs not cleared by low enable");

	a_clear_zero_run: assert property (@(posedge clk) disable iff (!rst_b)
		(!host.enable)[*2] |-> data_out == `CLR_WORD_ZERO && state_reg == CLR_CLEAR)
		else $error("outputs not zero between enable reads");

	a_hold_stable: assert property (@(posedge clk) disable iff (!rst_b)
		state_reg == CLR_HOLD && host.enable && host.rom_clock && $past(host.rom_clock)
		|=> $stable(data_out))
		else $error("latched word changed while clock high");

	a_precharge_ones: assert property (@(posedge clk) disable iff (!rst_b)
		state_reg == CLR_HOLD && host.enable && fall |=> data_out == `CLR_WORD_ONES
		##1 (!host.enable || data_out == $past(table_word)))
		else $error("clock read missed the ones pulse");

	a_fetch_word: assert property (@(posedge clk) disable iff (!rst_b)
		state_reg == CLR_FETCH && host.enable && !rise |=> data_out == $past(table_word))
		else $error("fetched word does not match address");

	a_rise_latch: assert property (@(posedge clk) disable iff (!rst_b)
		state_reg == CLR_FETCH && host.enable && rise
		|=> state_reg == CLR_HOLD && data_out == $past(data_out))
		else $error("clock rise did not latch the word");

	a_enable_direct: assert property (@(posedge clk) disable iff (!rst_b)
		state_reg == CLR_CLEAR && host.enable
		|=> data_out == $past(table_word) && state_reg != CLR_PRECHARGE)
		else $error("enable read showed a ones pulse");

	a_index_word: assert property (@(posedge clk) disable iff (!rst_b)
		state_reg == CLR_PRECHARGE && host.enable
		|=> data_out == ROM_TABLE[$past(host.address)])
		else $error("word index not plain binary");

	a_clear_state: assert property (@(posedge clk) disable iff (!rst_b)
		!host.enable |=> state_reg == CLR_CLEAR && !word_stale)
		else $error("low enable did not clear the latch");

	a_stale_clear: assert property (@(posedge clk) disable iff (!rst_b)
		host.enable && host.rom_clock |=> !word_stale)
		else $error("stale flag kept while device clock high");

	a_stale_set: assert property (@(posedge clk) disable iff (!rst_b)
		host.enable && !host.rom_clock && low_cnt_reg == 32'(`CLR_LOW_MAX_CYC)
		|=> word_stale)
		else $error("stale flag missed after long low phase");

	a_stale_low_only: assert property (@(posedge clk) disable iff (!rst_b)
		word_stale |-> $past(host.enable) && !$past(host.rom_clock))
		else $error("stale flag raised outside a low phase");

	a_hold_addr_ignored: assert property (@(posedge clk) disable iff (!rst_b)
		state_reg == CLR_HOLD && host.enable && !fall && $changed(host.address)
		|=> $stable(data_out))
		else $error("latched word followed the address");

	a_ones_one_cycle: assert property (@(posedge clk) disable iff (!rst_b)
		state_reg == CLR_PRECHARGE && host.enable |=> state_reg == CLR_FETCH)
		else $error("ones pulse lasted more than one cycle");

endmodule : clr_rom

// File: verilog/clr_regs.svh
/*
 * Constants for the clocked latched read-only store: geometry and timing counts.
 * Assumes a 10 MHz system clock; included by bare name.
 */
`ifndef CLR_REGS_SVH
`define CLR_REGS_SVH

`define CLR_ADDR_W        8
`define CLR_DATA_W        4
`define CLR_DEPTH         256
`define CLR_CLK_NS        100
// longest low phase of the device clock before the fetched word decays
`define CLR_LOW_MAX_MS    10
`define CLR_LOW_MAX_CYC   ((`CLR_LOW_MAX_MS * 1000000) / `CLR_CLK_NS)
// width of the precharge pulse seen between clock-driven reads
`define CLR_PRE_NS        100
`define CLR_PRE_CYC       (((`CLR_PRE_NS + `CLR_CLK_NS - 1) / `CLR_CLK_NS) < 1 ? 1 : \
	((`CLR_PRE_NS + `CLR_CLK_NS - 1) / `CLR_CLK_NS))
`define CLR_WORD_ZERO     4'h0
`define CLR_WORD_ONES     4'hF

`endif

// File: verilog/clr_pkg.sv
/*
 * Types for the clocked latched read-only store.
 * Assumes clr_regs.svh is on the include path.
 */
`include "clr_regs.svh"

package clr_pkg;

	typedef logic [`CLR_DATA_W-1:0] clr_word_t;
	typedef logic [`CLR_ADDR_W-1:0] clr_addr_t;

	// pins coming from the host, before and after synchronising
	typedef struct packed {
		logic      rom_clock;
		logic      enable;
		clr_addr_t address;
	} clr_host_t;

	typedef enum logic [1:0] {
		CLR_CLEAR,
		CLR_PRECHARGE,
		CLR_FETCH,
		CLR_HOLD
	} clr_state_t;

	// table content: fixed at build, never written at run time
	typedef clr_word_t clr_table_t [0:`CLR_DEPTH-1];

endpackage : clr_pkg

// File: verilog/clr_sync.sv
/*
 * Two-flop synchroniser for a bundle of host pins.
 * Assumes inputs are asynchronous to clk; stage one is read only by stage two.
 */
`timescale 1ns/10ps

module clr_sync
	import clr_pkg::*;
(
	// clock and reset
	input  wire logic      clk,
	input  wire logic      rst_b,
	// pins in, synchronised out
	input  wire clr_host_t pins,
	output clr_host_t      synced
);

	clr_host_t stage1_reg;
	clr_host_t stage2_reg;
	clr_host_t stage1_next;
	clr_host_t stage2_next;

	always_comb begin
		stage1_next = pins;
		stage2_next = stage1_reg;
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			stage1_reg <= '0;
			stage2_reg <= '0;
		end else begin
			stage1_reg <= stage1_next;
			stage2_reg <= stage2_next;
		end
	end

	assign synced = stage2_reg;

endmodule : clr_sync

// File: tb/clr_host_model.sv
/*
 * Host-side driver for the latched read-only store: clock, enable and address pins.
 * Assumes the bench calls drive() and that pins may move on any falling clk edge.
 */
`timescale 1ns/10ps

module clr_host_model
	import clr_pkg::*;
(
	// system clock
	input  wire logic clk,
	// host pins
	output logic      rom_clock,
	output logic      enable,
	output clr_addr_t address
);
	initial begin
		rom_clock = 1'b1;
		enable    = 1'b0;
		address   = '0;
	end

	// pins move on the falling edge, well away from the sampling edge
	task automatic drive(input logic c, input logic e, input clr_addr_t a);
		@(negedge clk);
		rom_clock = c; // callers keep each low phase a few cycles long
		enable    = e; // enable only drops while the clock is high
		address   = a;
	endtask : drive
endmodule : clr_host_model

// File: tb/clr_rom_tb.sv
/*
 * Self-checking bench for the latched read-only store, random and corner reads.
 * Assumes clr_pkg and clr_host_model are compiled first.
 */
`timescale 1ns/10ps

`include "clr_regs.svh"

module clr_rom_tb
	import clr_pkg::*;
;
	logic      clk;
	logic      rst_b;
	logic      rom_clock;
	logic      enable;
	clr_addr_t address;
	clr_word_t data_out;
	logic      word_stale;
	int        error_cnt;
	int        samples_checked;
	clr_addr_t a;
	clr_word_t last_want;

	function automatic clr_word_t exp_word(input clr_addr_t x);
		return x[3:0] ^ {x[6:4], x[7]};
	endfunction : exp_word

	function automatic clr_table_t make_table();
		clr_table_t t;
		for (int i = 0; i < `CLR_DEPTH; i++) begin
			t[i] = exp_word(clr_addr_t'(i));
		end
		return t;
	endfunction : make_table

	localparam clr_table_t TBL = make_table();

	clr_rom #(.ROM_TABLE(TBL)) clr_rom_inst (
		.clk(clk), .rst_b(rst_b), .rom_clock(rom_clock), .enable(enable),
		.address(address), .data_out(data_out), .word_stale(word_stale));

	clr_host_model clr_host_model_inst (
		.clk(clk), .rom_clock(rom_clock), .enable(enable), .address(address));

	initial clk = 1'b0;
	always #50 clk = ~clk;

	task automatic check(input clr_word_t seen, input clr_word_t want);
		samples_checked++;
		if (seen !== want) begin
			error_cnt++;
			$display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask : check

	// six cycles cover the sync delay; notes whether the all-ones pulse showed up.
	// an old or new word of all ones still stands in the window, so it counts too
	task automatic watch(input clr_word_t want, input logic pulse);
		logic saw;
		logic ones_exp;
		saw      = 1'b0;
		ones_exp = pulse | (want === `CLR_WORD_ONES) | (last_want === `CLR_WORD_ONES);
		repeat (6) begin
			@(negedge clk);
			if (data_out === `CLR_WORD_ONES) saw = 1'b1;
		end
		check(data_out, want);
		check({3'h0, saw}, {3'h0, ones_exp});
		check({3'h0, word_stale}, 4'h0);
		last_want = want;
	endtask : watch

	task automatic print_verdict();
		$display("checked=%0d errors=%0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : print_verdict

	initial begin
		#5_000_000;
		error_cnt++;
		print_verdict();
	end

	initial begin
		error_cnt = 0;
		samples_checked = 0;
		last_want = `CLR_WORD_ZERO;
		rst_b = 1'b0;
		void'($urandom(32'h3222));
		repeat (3) @(negedge clk);
		rst_b = 1'b1;
		check(data_out, `CLR_WORD_ZERO);
		check({3'h0, word_stale}, 4'h0);
		// corners first, then random addresses
		for (int n = 0; n < 40; n++) begin
			a = (n == 0) ? 8'h00 : (n == 1) ? 8'hFF : clr_addr_t'($urandom);
			clr_host_model_inst.drive(1'b1, 1'b0, a);
			watch(`CLR_WORD_ZERO, 1'b0);
			clr_host_model_inst.drive(1'b1, 1'b1, a);
			watch(exp_word(a), 1'b0);
			clr_host_model_inst.drive(1'b0, 1'b1, ~a);
			watch(exp_word(~a), 1'b1);
			clr_host_model_inst.drive(1'b1, 1'b1, ~a);
			clr_host_model_inst.drive(1'b1, 1'b1, a ^ 8'h5A);
			watch(exp_word(~a), 1'b0);
		end
		print_verdict();
	end
endmodule : clr_rom_tb
